// *** logic/storage_elements.sv ***
// Storage elements: half latch, master-slave counter and shift register, one-bit stages.
//
// Contract
// - Half latch usable alone; two form flip-flop.
// - Master captures set/reset while true clock active.
// - Slave copies master only on complementary clock.
// - Counter stage toggles when previous output falls.
// - Decoded multi-stage outputs are sampled by clock.
// - Shift stage: master on true, slave on complement.
// - Clock generator outputs never in same state.
// - Transfer phase loads; hold keeps; output follows later.
// - Static feedback phase latches output until transfer; here feedback ends with SEQ_FB and stays off in SEQ_IDLE.
// - Transfer and hold never active together.
// - Transfer and hold each on 500 ns least.
// - Hold off, transfer on, 50 us at most.
// - Transfer end to feedback: 500 ns..50 us.
// - Feedback may be omitted above 100 kHz.
// - Dynamic stage: no feedback, relies on storage.
// - Phase rate kept between 10 kHz and 1 MHz; the phases stop in SEQ_IDLE while no data waits.
`timescale 1ns/1ps
module storage_elements #(
   parameter int COUNT_STAGES = storage_pkg::COUNT_STAGES,
   parameter int SHIFT_STAGES = storage_pkg::SHIFT_STAGES,
   parameter int STORE_MAX_CYC = storage_pkg::STORE_MAX_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Stand-alone set-reset latch
   input wire logic i_sr_set,
   input wire logic i_sr_reset,
   output logic o_sr_q,
   // Master-slave shift register
   input wire logic i_ms_din,
   output logic [SHIFT_STAGES-1:0] o_ms_shift,
   // Ripple counter
   output logic [COUNT_STAGES-1:0] o_count,
   // One-bit stages
   output logic o_static_q,
   output logic o_dynamic_q,
   output logic o_static_decayed,
   output logic o_dynamic_decayed,
   // Link
   phase_link_if.dev link
);
   // Each chain feeds stage k from stage k-1, so a chain needs at least two stages.
   if (COUNT_STAGES < 2 || SHIFT_STAGES < 2 || STORE_MAX_CYC < 1 || STORE_MAX_CYC >= 65536) begin : g_bad
      $error("storage element sizes out of range");
   end

   // Half flip-flop cell: set wins alone, reset wins alone, both low hold.
   function automatic logic half_ff(input logic set, input logic rst, input logic q);
      half_ff = (set & ~rst) | (q & ~(rst & ~set));
   endfunction

   // ****************************************
   // Clock generator
   // ****************************************
   logic clk_t_r;
   logic clk_n_r;
   // Both outputs switch on the same edge from one source, so they stay complementary.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_t_r <= 1'b0;
         clk_n_r <= 1'b1;
      end else begin
         clk_t_r <= link.sq_wave;
         clk_n_r <= ~link.sq_wave;
      end
   end

   // ****************************************
   // Stand-alone latch
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sr_q <= 1'b0;
      end else begin
         o_sr_q <= half_ff(i_sr_set, i_sr_reset, o_sr_q);
      end
   end

   // ****************************************
   // Ripple counter
   // ****************************************
   logic [COUNT_STAGES-1:0] cnt_m_r;
   logic [COUNT_STAGES-1:0] cnt_ct;
   logic [COUNT_STAGES-1:0] cnt_cn;
   // Stage k is clocked by the output of stage k-1, so changes ripple one cycle per stage.
   // A wide decode of o_count may see a false count while it ripples.
   always_comb begin
      cnt_ct = {o_count[COUNT_STAGES-2:0], clk_t_r};
      cnt_cn = {~o_count[COUNT_STAGES-2:0], clk_n_r};
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_m_r <= '0;
         o_count <= '0;
      end else begin
         for (int k = 0; k < COUNT_STAGES; k++) begin
            if (cnt_ct[k]) begin
               cnt_m_r[k] <= half_ff(~o_count[k], o_count[k], cnt_m_r[k]);
            end
            if (cnt_cn[k]) begin
               o_count[k] <= cnt_m_r[k];
            end
         end
      end
   end

   // ****************************************
   // Master-slave shift register
   // ****************************************
   logic [SHIFT_STAGES-1:0] sh_m_r;
   logic [SHIFT_STAGES-1:0] sh_in;
   always_comb begin
      sh_in = {o_ms_shift[SHIFT_STAGES-2:0], i_ms_din};
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sh_m_r <= '0;
         o_ms_shift <= '0;
      end else begin
         for (int k = 0; k < SHIFT_STAGES; k++) begin
            if (clk_t_r) begin
               sh_m_r[k] <= half_ff(sh_in[k], ~sh_in[k], sh_m_r[k]);
            end
            if (clk_n_r) begin
               o_ms_shift[k] <= sh_m_r[k];
            end
         end
      end
   end

   // ****************************************
   // One-bit stages
   // ****************************************
   logic st_in_node_r;
   logic st_hold_node_r;
   logic dy_in_node_r;
   logic dy_hold_node_r;
   logic [15:0] st_age_r;
   logic [15:0] dy_age_r;
   // Static stage: input node loads during transfer, hold node copies it during hold.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_in_node_r <= 1'b0;
         st_hold_node_r <= 1'b0;
         o_static_q <= 1'b0;
      end else begin
         if (link.ph_xfer) begin
            st_in_node_r <= link.ser_din;
         end
         if (link.ph_fb) begin
            // Feedback closes the loop, so the node is refreshed from the output.
            st_in_node_r <= o_static_q;
         end
         if (link.ph_hold) begin
            st_hold_node_r <= st_in_node_r;
         end
         o_static_q <= st_hold_node_r;
      end
   end
   // Dynamic stage: same path, no feedback.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         dy_in_node_r <= 1'b0;
         dy_hold_node_r <= 1'b0;
         o_dynamic_q <= 1'b0;
      end else begin
         if (link.ph_xfer) begin
            dy_in_node_r <= link.ser_din;
         end
         if (link.ph_hold) begin
            dy_hold_node_r <= dy_in_node_r;
         end
         o_dynamic_q <= dy_hold_node_r;
      end
   end
   // Charge on a node only lasts a limited time; the age counters flag data that was not refreshed.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_age_r <= '0;
         o_static_decayed <= 1'b0;
      end else begin
         if (link.ph_xfer || link.ph_fb) begin
            st_age_r <= '0;
         end else if (st_age_r != 16'hFFFF) begin
            st_age_r <= st_age_r + 16'h0001;
         end
         o_static_decayed <= (st_age_r > 16'(STORE_MAX_CYC)) && !link.ph_xfer && !link.ph_fb;
      end
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         dy_age_r <= '0;
         o_dynamic_decayed <= 1'b0;
      end else begin
         if (link.ph_xfer) begin
            dy_age_r <= '0;
         end else if (dy_age_r != 16'hFFFF) begin
            dy_age_r <= dy_age_r + 16'h0001;
         end
         o_dynamic_decayed <= (dy_age_r > 16'(STORE_MAX_CYC)) && !link.ph_xfer;
      end
   end

   // Stage output returned to the source comes from the static stage.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         link.stage_q <= 1'b0;
      end else begin
         link.stage_q <= o_static_q;
      end
   end
endmodule

// *** logic/storage_pkg.sv ***
// Shared timing constants and encodings for the storage element ends.
package storage_pkg;
   // ****************************************
   // Clock and phase timing
   // ****************************************
   localparam int MCLK_HZ = 100_000_000;
   localparam int MCLK_PERIOD_NS = 1_000_000_000 / MCLK_HZ;
   // Least on time of the transfer and hold phases, and least transfer-to-feedback delay.
   localparam int PHASE_MIN_NS = 500;
   // Longest storage time of a node: caps transfer on time, hold off time and feedback delay.
   localparam int STORE_MAX_US = 50;
   // Above this phase rate the feedback phase may be left out.
   localparam int NOFB_MIN_KHZ = 100;
   // Allowed phase rate range.
   localparam int RATE_MIN_KHZ = 10;
   localparam int RATE_MAX_KHZ = 1000;
   // Least on times round up; longest times and both rate periods round down.
   localparam int PHASE_MIN_CYC = (PHASE_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int STORE_MAX_CYC = (STORE_MAX_US * 1000) / MCLK_PERIOD_NS;
   localparam int NOFB_MAX_PERIOD_CYC = MCLK_HZ / (NOFB_MIN_KHZ * 1000);
   localparam int RATE_MIN_PERIOD_CYC = MCLK_HZ / (RATE_MAX_KHZ * 1000);
   localparam int RATE_MAX_PERIOD_CYC = MCLK_HZ / (RATE_MIN_KHZ * 1000);
   // ****************************************
   // Sizes and defaults
   // ****************************************
   localparam int COUNT_STAGES = 4;
   localparam int SHIFT_STAGES = 4;
   localparam int TIMER_W = 16;
   localparam int XFER_NS_DEF = 1000;
   localparam int HOLD_NS_DEF = 1000;
   localparam int TAU_NS_DEF = 1000;
   localparam int BUF_DEPTH = 2;
   // ****************************************
   // Sequencer states, Gray along the usual path
   // ****************************************
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h0,
      SEQ_XFER = 2'h1,
      SEQ_HOLD = 2'h3,
      SEQ_FB = 2'h2
   } seq_state_t;
endpackage

// *** logic/phase_link_if.sv ***
// Link between the phase source and the storage elements.
`timescale 1ns/1ps
interface phase_link_if;
   logic sq_wave;
   logic ser_din;
   logic ph_xfer;
   logic ph_hold;
   logic ph_fb;
   logic stage_q;
   modport dev (
      input sq_wave,
      input ser_din,
      input ph_xfer,
      input ph_hold,
      input ph_fb,
      output stage_q
   );
   modport src (
      output sq_wave,
      output ser_din,
      output ph_xfer,
      output ph_hold,
      output ph_fb,
      input stage_q
   );
endinterface

// *** logic/phase_source.sv ***
// Multiphase source: sequences transfer, hold and feedback phases and feeds buffered data.
`timescale 1ns/1ps
module phase_source #(
   parameter int XFER_NS = storage_pkg::XFER_NS_DEF,
   parameter int HOLD_NS = storage_pkg::HOLD_NS_DEF,
   parameter int TAU_NS = storage_pkg::TAU_NS_DEF,
   parameter bit FB_EN = 1'b1,
   parameter int STORE_MAX_CYC = storage_pkg::STORE_MAX_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Data stream in
   input wire logic i_din,
   input wire logic i_din_valid,
   output logic o_din_ready,
   // Count pulses, fed as a square wave to the clock generator
   input wire logic i_count_sq,
   // Sampled stage output
   output logic o_dout,
   output logic o_dout_valid,
   // Link
   phase_link_if.src link
);
   localparam int XFER_CYC = (XFER_NS + storage_pkg::MCLK_PERIOD_NS - 1) / storage_pkg::MCLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + storage_pkg::MCLK_PERIOD_NS - 1) / storage_pkg::MCLK_PERIOD_NS;
   localparam int TAU_CYC = (TAU_NS + storage_pkg::MCLK_PERIOD_NS - 1) / storage_pkg::MCLK_PERIOD_NS;
   localparam int PERIOD_CYC = XFER_CYC + HOLD_CYC;

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (XFER_CYC < storage_pkg::PHASE_MIN_CYC || HOLD_CYC < storage_pkg::PHASE_MIN_CYC) begin : g_bad_on
      $error("phase on time below the least on time");
   end
   if (XFER_CYC > STORE_MAX_CYC) begin : g_bad_xfer
      $error("transfer phase longer than the storage time");
   end
   if (FB_EN && (TAU_CYC < storage_pkg::PHASE_MIN_CYC || TAU_CYC > STORE_MAX_CYC
                 || TAU_CYC >= HOLD_CYC)) begin : g_bad_tau
      $error("feedback delay out of range");
   end
   if (!FB_EN && PERIOD_CYC > storage_pkg::NOFB_MAX_PERIOD_CYC) begin : g_bad_nofb
      $error("feedback phase may only be left out above the no-feedback rate");
   end
   if (PERIOD_CYC < storage_pkg::RATE_MIN_PERIOD_CYC || PERIOD_CYC > storage_pkg::RATE_MAX_PERIOD_CYC
       || PERIOD_CYC >= (1 << storage_pkg::TIMER_W)) begin : g_bad_rate
      $error("phase rate out of range");
   end

   // ****************************************
   // Two-entry data buffer
   // ****************************************
   localparam int BUF_DEPTH_M1 = storage_pkg::BUF_DEPTH - 1;
   logic [BUF_DEPTH_M1:0] buf_r;
   logic [1:0] buf_cnt_r;
   logic buf_pop;
   logic buf_push;
   assign buf_push = i_din_valid && o_din_ready;
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         buf_r <= '0;
         buf_cnt_r <= 2'h0;
      end else begin
         if (buf_pop) begin
            buf_r[0] <= buf_r[1];
         end
         if (buf_push) begin
            buf_r[buf_cnt_r[0] & ~buf_pop] <= i_din;
         end
         buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end
   // Ready is registered so a full buffer stalls the producer.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_din_ready <= 1'b0;
      end else begin
         o_din_ready <= (buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop}) < 2'h2;
      end
   end

   // ****************************************
   // Phase sequencer
   // ****************************************
   storage_pkg::seq_state_t state_r;
   logic [storage_pkg::TIMER_W-1:0] timer_r;
   assign buf_pop = (state_r == storage_pkg::SEQ_IDLE) && (buf_cnt_r != 2'h0);
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= storage_pkg::SEQ_IDLE;
         timer_r <= '0;
      end else begin
         timer_r <= timer_r + 1'b1;
         case (state_r)
            storage_pkg::SEQ_IDLE: begin
               // Hold may stay on indefinitely while no data waits.
               if (buf_pop) begin
                  state_r <= storage_pkg::SEQ_XFER;
                  timer_r <= '0;
               end
            end
            storage_pkg::SEQ_XFER: begin
               if (timer_r == storage_pkg::TIMER_W'(XFER_CYC - 1)) begin
                  state_r <= storage_pkg::SEQ_HOLD;
                  timer_r <= '0;
               end
            end
            storage_pkg::SEQ_HOLD: begin
               if (FB_EN && timer_r == storage_pkg::TIMER_W'(TAU_CYC - 1)) begin
                  state_r <= storage_pkg::SEQ_FB;
               end else if (!FB_EN && timer_r == storage_pkg::TIMER_W'(HOLD_CYC - 1)) begin
                  state_r <= storage_pkg::SEQ_IDLE;
               end
            end
            storage_pkg::SEQ_FB: begin
               if (timer_r == storage_pkg::TIMER_W'(HOLD_CYC - 1)) begin
                  state_r <= storage_pkg::SEQ_IDLE;
               end
            end
            default: begin
               state_r <= storage_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Link drivers
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         link.ph_xfer <= 1'b0;
         link.ph_hold <= 1'b1;
         link.ph_fb <= 1'b0;
         link.ser_din <= 1'b0;
         link.sq_wave <= 1'b0;
      end else begin
         // Both phases come from one state, so they are never on together.
         link.ph_xfer <= (state_r == storage_pkg::SEQ_XFER);
         link.ph_hold <= (state_r != storage_pkg::SEQ_XFER);
         link.ph_fb <= (state_r == storage_pkg::SEQ_FB);
         if (buf_pop) begin
            link.ser_din <= buf_r[0];
         end
         link.sq_wave <= i_count_sq;
      end
   end

   // The stage output is sampled by the clock, never used while it settles.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_dout <= 1'b0;
         o_dout_valid <= 1'b0;
      end else begin
         o_dout_valid <= (state_r != storage_pkg::SEQ_IDLE) && buf_pop == 1'b0
                         && timer_r == storage_pkg::TIMER_W'(HOLD_CYC - 1)
                         && state_r != storage_pkg::SEQ_XFER;
         if (state_r != storage_pkg::SEQ_XFER && timer_r == storage_pkg::TIMER_W'(HOLD_CYC - 1)) begin
            o_dout <= link.stage_q;
         end
      end
   end
endmodule

// *** bench/storage_asserts.sv ***
// Concurrent checks on the phase link between the source and the storage elements.
`timescale 1ns/1ps
module storage_asserts #(
   parameter int STORE_MAX_CYC = storage_pkg::STORE_MAX_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Link signals
   input wire logic sq_wave,
   input wire logic ser_din,
   input wire logic ph_xfer,
   input wire logic ph_hold,
   input wire logic ph_fb,
   input wire logic stage_q
);
   int xfer_cnt;
   int hold_cnt;
   int gap_cnt;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // ****
   // Phase timers
   // ****
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) xfer_cnt <= 0;
      else xfer_cnt <= ph_xfer ? xfer_cnt + 1 : 0;
   end
   // Hold is treated as long held through reset, so the first transfer is not flagged.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) hold_cnt <= storage_pkg::PHASE_MIN_CYC;
      else hold_cnt <= ph_hold ? hold_cnt + 1 : 0;
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) gap_cnt <= 0;
      else gap_cnt <= ph_xfer ? 0 : gap_cnt + 1;
   end
   // ****
   // Properties
   // ****
   sequence xfer_done;
      $fell(ph_xfer) ##1 ph_hold;
   endsequence
   a_phase_complement: assert property (ph_xfer != ph_hold)
      else $error("transfer and hold phases not complementary");
   a_xfer_min_on: assert property ($fell(ph_xfer) |-> xfer_cnt >= storage_pkg::PHASE_MIN_CYC)
      else $error("transfer phase too short");
   a_hold_min_on: assert property ($fell(ph_hold) |-> hold_cnt >= storage_pkg::PHASE_MIN_CYC)
      else $error("hold phase too short");
   a_xfer_max_on: assert property (xfer_cnt <= STORE_MAX_CYC)
      else $error("transfer phase too long");
   a_fb_delay: assert property ($rose(ph_fb) |-> gap_cnt >= storage_pkg::PHASE_MIN_CYC
      && gap_cnt <= STORE_MAX_CYC)
      else $error("feedback delay out of range");
   a_fb_in_hold: assert property (ph_fb |-> ph_hold && !ph_xfer)
      else $error("feedback outside hold phase");
   a_stage_loads: assert property (xfer_done |-> ##[1:4] (stage_q == ser_din))
      else $error("stage output did not take data");
   a_data_stable: assert property (ph_xfer && $past(ph_xfer) |-> $stable(ser_din))
      else $error("data moved during transfer");
   a_fb_keeps: assert property (ph_fb && $past(ph_fb) |-> $stable(stage_q))
      else $error("stage output moved under feedback");
   c_feedback: cover property ($rose(ph_fb));
endmodule

// *** bench/test_master_slave_and_shift_storage.sv ***
// Self-checking bench for the phase source and storage elements joined by the phase link.
`timescale 1ns/1ps
module test_master_slave_and_shift_storage;
   localparam int STORE_CYC = 200;
   localparam int XFER_NS = 1000;
   localparam int HOLD_NS = 2000;
   localparam int TAU_NS = 1000;
   // Each entry is set, reset and the expected latch output after it.
   localparam logic [2:0] LAT [7] = '{3'h5, 3'h1, 3'h7, 3'h2, 3'h0, 3'h6, 3'h5};
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic din = 1'b0;
   logic din_valid = 1'b0;
   logic count_sq = 1'b0;
   logic sr_set = 1'b0;
   logic sr_reset = 1'b0;
   logic ms_din = 1'b0;
   logic din_ready, dout, dout_valid, sr_q, static_q, dynamic_q, static_b, dynamic_b, decay_b;
   logic static_dec, static_dec_b;
   logic [3:0] ms_shift;
   logic [3:0] count;
   int fails = 0;
   int checks_done = 0;
   int exp_q[$];
   bit seen_full = 1'b0;
   always #5 i_mclk = ~i_mclk;
   phase_link_if link();
   phase_link_if link2();
   phase_source #(.XFER_NS(XFER_NS), .HOLD_NS(HOLD_NS), .TAU_NS(TAU_NS), .STORE_MAX_CYC(STORE_CYC))
   u_phase_source (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_din(din), .i_din_valid(din_valid),
      .o_din_ready(din_ready), .i_count_sq(count_sq), .o_dout(dout), .o_dout_valid(dout_valid), .link(link));
   storage_elements #(.STORE_MAX_CYC(STORE_CYC)) u_storage_elements (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_sr_set(sr_set), .i_sr_reset(sr_reset), .o_sr_q(sr_q),
      .i_ms_din(ms_din), .o_ms_shift(ms_shift), .o_count(count), .o_static_q(static_q),
      .o_dynamic_q(dynamic_q), .o_static_decayed(static_dec), .o_dynamic_decayed(), .link(link));
   // Second stage is driven directly by the bench, with no feedback phase and long gaps.
   storage_elements #(.STORE_MAX_CYC(STORE_CYC)) u_storage_elements2 (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_sr_set(sr_set), .i_sr_reset(sr_reset), .o_sr_q(),
      .i_ms_din(ms_din), .o_ms_shift(), .o_count(), .o_static_q(static_b),
      .o_dynamic_q(dynamic_b), .o_static_decayed(static_dec_b), .o_dynamic_decayed(decay_b), .link(link2));
   storage_asserts #(.STORE_MAX_CYC(STORE_CYC)) u_storage_asserts (.i_mclk(i_mclk), .i_nrst(i_nrst),
      .sq_wave(link.sq_wave), .ser_din(link.ser_din), .ph_xfer(link.ph_xfer), .ph_hold(link.ph_hold),
      .ph_fb(link.ph_fb), .stage_q(link.stage_q));
   // ****
   // Tasks
   // ****
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic send_bit(input bit b);
      din <= b;
      din_valid <= 1'b1;
      forever begin
         @(posedge i_mclk);
         if (din_ready === 1'b1) break;
         seen_full = 1'b1;
      end
      exp_q.push_back(b);
   endtask
   // ****
   // Result model
   // ****
   always @(posedge i_mclk) begin
      if (dout_valid === 1'b1) begin
         check(4'(dout), 4'(exp_q.size() > 0 ? exp_q.pop_front() : 2));
      end
   end
   initial begin
      cyc(40000);
      fails++;
      $display("Watchdog expired");
      finish_test();
   end
   // ****
   // Tests
   // ****
   initial begin
      logic [3:0] sh_exp;
      int cnt_exp;
      bit b;
      link2.sq_wave <= 1'b0;
      link2.ser_din <= 1'b0;
      link2.ph_xfer <= 1'b0;
      link2.ph_hold <= 1'b1;
      link2.ph_fb <= 1'b0;
      void'($urandom(32'h36309BEE));
      cyc(6);
      i_nrst <= 1'b1;
      cyc(2);
      for (int i = 0; i < 7; i++) begin
         sr_set <= LAT[i][2];
         sr_reset <= LAT[i][1];
         cyc(3);
         check(4'(sr_q), 4'(LAT[i][0]));
      end
      $display("Test latch done");
      cnt_exp = 0;
      sh_exp = 4'h0;
      for (int i = 0; i < 40; i++) begin
         b = 1'($urandom);
         ms_din <= b;
         cyc(2);
         count_sq <= 1'b1;
         cyc(2 + $urandom % 6);
         count_sq <= 1'b0;
         cyc(12 + $urandom % 6);
         cnt_exp++;
         sh_exp = {sh_exp[2:0], b};
         check(count, 4'(cnt_exp));
         check(ms_shift, sh_exp);
      end
      $display("Test counter and shift register done");
      for (int i = 0; i < 6; i++) begin
         b = 1'($urandom);
         send_bit(b);
      end
      din_valid <= 1'b0;
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) cyc(1);
      cyc(10);
      check(4'(exp_q.size()), 4'h0);
      check(4'(seen_full), 4'h1);
      check(4'(static_q), 4'(b));
      check(4'(dynamic_q), 4'(b));
      // The hold phase outlasts the storage time, so only the feedback refresh keeps this flag low.
      check(4'(static_dec), 4'h0);
      $display("Test stream done");
      for (int i = 0; i < 4; i++) begin
         b = 1'($urandom);
         link2.ser_din <= b;
         // Hold must stay on for the least on time before the next transfer.
         cyc(50);
         link2.ph_hold <= 1'b0;
         link2.ph_xfer <= 1'b1;
         cyc(60);
         link2.ph_xfer <= 1'b0;
         link2.ph_hold <= 1'b1;
         cyc(6);
         check(4'(dynamic_b), 4'(b));
         check(4'(static_b), 4'(b));
         check(4'(decay_b), 4'h0);
         check(4'(static_dec_b), 4'h0);
      end
      // Leaving transfers out for too long must show charge loss on both the dynamic and the static node, as link2 has no feedback phase.
      cyc(2 * STORE_CYC + 10);
      check(4'(decay_b), 4'h1);
      check(4'(static_dec_b), 4'h1);
      $display("Test bench-driven stage done");
      finish_test();
   end
endmodule
